// ===== hw/scg_crc.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module scg_crc #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic polySelBit0,
    input wire logic polySelBit1,
    input wire logic polySelBit2,
    input wire logic shiftClockN,
    input wire logic serialData,
    input wire logic checkWordEnable,
    input wire logic residueMatchEnableN,
    input wire logic presetN,
    input wire logic masterClear,
    output logic checkCharacter,
    output logic errorFlag,
    input wire logic [scg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Count must fit the 32-bit read word
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must lie between 1 and 32");
    end

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    scg_pkg::scg_pins_t rawPins;
    scg_pkg::scg_pins_t pins;

    // All pins share one pipeline so they stay aligned to the clock pin
    always_comb begin
        rawPins.polySel = {polySelBit2, polySelBit1, polySelBit0};
        rawPins.dataIn = serialData;
        rawPins.checkWordEnable = checkWordEnable;
        rawPins.residueMatchEnableN = residueMatchEnableN;
        rawPins.presetN = presetN;
        rawPins.masterClear = masterClear;
        rawPins.shiftClockN = shiftClockN;
    end

    scg_sync #(
        .W($bits(scg_pkg::scg_pins_t)),
        .RST_VAL(scg_pkg::PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async(rawPins),
        .synced(pins)
    );

    // ****************************************************************
    // Shift clock edge detect
    // ****************************************************************
    logic shiftClkPrev;
    logic shiftEdge;

    // Previous synchronised level of the shift clock pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shiftClkPrev <= 1'b1;
        end else begin
            shiftClkPrev <= pins.shiftClockN;
        end
    end

    // High-to-low transition of the shift clock captures one bit
    assign shiftEdge = shiftClkPrev & ~pins.shiftClockN; // RULE_10

    // ****************************************************************
    // Register port writes
    // ****************************************************************
    logic softClear;
    logic softPreset;

    // One-cycle init pulses; acting a cycle late keeps decode off the datapath
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            softClear <= 1'b0;
            softPreset <= 1'b0;
        end else begin
            softClear <= regWrite && (regAddr == scg_pkg::OFS_CONTROL)
                && regWdata[scg_pkg::CTRL_CLEAR_BIT];
            softPreset <= regWrite && (regAddr == scg_pkg::OFS_CONTROL)
                && regWdata[scg_pkg::CTRL_PRESET_BIT];
        end
    end

    // ****************************************************************
    // Division datapath
    // ****************************************************************
    scg_pkg::scg_word_t crcReg;
    scg_pkg::scg_word_t next_crc;
    scg_pkg::scg_word_t polyMask;
    scg_pkg::scg_word_t stageMask;
    logic matchMode;
    logic next_match;
    logic clearAct;
    logic presetAct;
    logic feedback;

    // Pin and soft controls act independently of one another
    assign clearAct = pins.masterClear | softClear; // RULE_15
    assign presetAct = ~pins.presetN | softPreset; // RULE_15

    // Taps and active stages of the chosen divisor
    assign polyMask = scg_pkg::POLY_MASK[pins.polySel]; // RULE_07
    assign stageMask = scg_pkg::STAGE_MASK[pins.polySel]; // RULE_03

    // Incoming bit against the top stage steers the taps
    assign feedback = pins.dataIn ^ crcReg[scg_pkg::CRC_W-1]; // RULE_11

    // Next register image; clear wins over preset when both are held
    always_comb begin
        next_crc = crcReg; // RULE_19
        next_match = matchMode;
        if (clearAct) begin
            next_crc = scg_pkg::ZERO_WORD; // RULE_18 RULE_08
            next_match = 1'b0;
        end else if (presetAct) begin
            next_crc = stageMask; // RULE_18 RULE_08
            next_match = 1'b0;
        end else if (shiftEdge) begin
            // Match enable sampled on each bit; the last bit's value sticks
            next_match = ~pins.residueMatchEnableN; // RULE_17
            if (pins.checkWordEnable) begin
                // Modulo-2 subtract of the divisor is a plain XOR
                next_crc = {crcReg[scg_pkg::CRC_W-2:0], 1'b0}
                    ^ (feedback ? polyMask : scg_pkg::ZERO_WORD); // RULE_01 RULE_02 RULE_05 RULE_12
            end else begin
                // Remainder leaves the top; zeros fill from below
                next_crc = {crcReg[scg_pkg::CRC_W-2:0], 1'b0}; // RULE_13 RULE_04
            end
        end
    end

    // Remainder storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crcReg <= scg_pkg::ZERO_WORD;
            matchMode <= 1'b0;
        end else begin
            crcReg <= next_crc;
            matchMode <= next_match;
        end
    end

    // Top stage is the serial check output; the line merge is outside
    assign checkCharacter = crcReg[scg_pkg::CRC_W-1]; // RULE_04 RULE_14

    // ****************************************************************
    // Error flag
    // ****************************************************************
    // Evaluated from the same next image, so it moves with the register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            errorFlag <= 1'b0;
        end else if (next_match) begin
            errorFlag <= (next_crc != scg_pkg::RESIDUE); // RULE_06 RULE_17
        end else begin
            errorFlag <= (next_crc != scg_pkg::ZERO_WORD); // RULE_16 RULE_05
        end
    end

    // ****************************************************************
    // Message phase and bit count
    // ****************************************************************
    scg_pkg::scg_phase_t phase;
    logic [CNT_W-1:0] bitCount;

    // Tracks where the controller is in the message
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= scg_pkg::PH_IDLE;
        end else if (clearAct || presetAct) begin
            phase <= scg_pkg::PH_IDLE;
        end else if (shiftEdge) begin
            phase <= pins.checkWordEnable ? scg_pkg::PH_DATA : scg_pkg::PH_CHECK;
        end
    end

    // Counts captured bits since the last init; wraps silently
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitCount <= '0;
        end else if (clearAct || presetAct) begin
            bitCount <= '0;
        end else if (shiftEdge) begin
            bitCount <= bitCount + 1'b1;
        end
    end

    // ****************************************************************
    // Register port reads
    // ****************************************************************
    scg_pkg::scg_word_t justified;

    // Short remainders brought down to bit 0 for software
    assign justified = crcReg >> scg_pkg::JUST_SHIFT[pins.polySel]; // RULE_09

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h0000_0000;
        end else if (!regRead) begin
            regRdata <= 32'h0000_0000;
        end else begin
            unique case (regAddr)
                scg_pkg::OFS_STATUS: begin
                    regRdata <= {10'h000, pins.polySel, phase, errorFlag, justified};
                end
                scg_pkg::OFS_COUNT: begin
                    regRdata <= 32'(bitCount);
                end
                default: begin
                    // Control and unmapped offsets read as zero
                    regRdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic initAct;
    assign initAct = clearAct | presetAct;

    a_clear_zeroes: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
        clearAct |=> (crcReg == scg_pkg::ZERO_WORD) && !errorFlag)
        else $error("clear did not empty the register");

    a_preset_stages: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
        presetAct && !clearAct |=> crcReg == $past(stageMask))
        else $error("preset image wrong for selected degree");

    a_hold_between: assert property (@(posedge clk) disable iff (!rstn) // RULE_19
        !shiftEdge && !initAct |=> $stable(crcReg))
        else $error("register moved without a shift edge");

    a_taps_applied: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        shiftEdge && !initAct && pins.checkWordEnable && feedback
        |=> crcReg == ({$past(crcReg[14:0]), 1'b0} ^ $past(polyMask)))
        else $error("feedback taps not applied");

    a_taps_skipped: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        shiftEdge && !initAct && pins.checkWordEnable && !feedback
        |=> crcReg == {$past(crcReg[14:0]), 1'b0})
        else $error("taps applied without feedback");

    a_check_shift: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
        shiftEdge && !initAct && !pins.checkWordEnable
        |=> checkCharacter == $past(crcReg[14]) && phase == scg_pkg::PH_CHECK)
        else $error("check bit not shifted out");

    a_error_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        !matchMode |-> errorFlag == (crcReg != scg_pkg::ZERO_WORD))
        else $error("error flag disagrees with zero test");

    a_error_residue: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        matchMode |-> errorFlag == (crcReg != scg_pkg::RESIDUE))
        else $error("error flag disagrees with residue test");

    a_edge_single: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        shiftEdge |=> !shiftEdge ##1 !shiftEdge || pins.shiftClockN)
        else $error("shift edge seen twice in a row");

    a_status_read: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        regRead && regAddr == scg_pkg::OFS_STATUS
        |=> regRdata[15:0] == $past(justified) && regRdata[16] == $past(errorFlag))
        else $error("status read does not show remainder");

    c_feedback_shift: cover property (@(posedge clk) disable iff (!rstn)
        shiftEdge && pins.checkWordEnable && feedback);

    c_residue_pass: cover property (@(posedge clk) disable iff (!rstn)
        matchMode && !errorFlag);

    c_zero_pass: cover property (@(posedge clk) disable iff (!rstn)
        phase == scg_pkg::PH_DATA && !matchMode && !errorFlag && bitCount > 8);

    c_check_out: cover property (@(posedge clk) disable iff (!rstn)
        phase == scg_pkg::PH_CHECK && checkCharacter);

endmodule

`default_nettype wire

// ===== hw/scg_pkg.sv
// Overview of operation
// RULE_01 - Divide the serial stream by the selected polynomial, keeping the remainder.
// RULE_02 - Division is a shift register with exclusive-OR feedback taps.
// RULE_03 - Active register stages equal the degree of the selected polynomial.
// RULE_04 - On transmit, the final remainder is supplied as the check character.
// RULE_05 - On receive, the same division runs; an error-free message leaves zero.
// RULE_06 - In link-control mode a remainder equal to the residue pattern is correct.
// RULE_07 - Eight generator polynomials, chosen by a 3-bit select input.
// RULE_08 - Accumulation may start from all zeros or all ones.
// RULE_09 - Remainders of degree below 16 are right-justified.
// RULE_10 - Data bits are presented on the data input, captured on the clock's falling edge.
// RULE_11 - Data bit XOR register top bit decides whether feedback taps apply.
// RULE_12 - Controller holds check-word enable high while message bits shift in.
// RULE_13 - With check-word enable low, the remainder shifts out one bit per clock.
// RULE_14 - External gating merges the check bits onto the line after the data.
// RULE_15 - Independent preset and clear controls for the register.
// RULE_16 - Error low for zero register, high otherwise, held until next edge or init.
// RULE_17 - With match enable low at the last bit, error low only on residue match.
// RULE_18 - Clear zeroes register; preset sets all active stages, clears the rest.
// RULE_19 - Register changes only on a shift edge, preset or clear.
// RULE_20 - Controller keeps the polynomial select stable for a whole message.

package scg_pkg;

    // ****************************************************************
    // Register geometry and residue
    // ****************************************************************
    localparam int CRC_W = 16;
    typedef logic [CRC_W-1:0] scg_word_t;
    localparam scg_word_t RESIDUE = 16'h1d0f; // Pattern x0..x15 = 1111000010111000
    localparam scg_word_t ZERO_WORD = 16'h0000;
    localparam int SEL_W = 3;
    localparam int NUM_POLY = 8;

    // ****************************************************************
    // Polynomial tables, taps aligned to the top of the register
    // ****************************************************************
    // Low taps of each divisor, shifted so stage x^deg sits above bit 15
    localparam scg_word_t POLY_MASK [NUM_POLY] = '{
        16'h8005, // x16+x15+x2+1
        16'h4003, // x16+x14+x+1
        16'ha097, // x16+x15+x13+x7+x4+x2+x+1
        16'h80f0, // x12+x11+x3+x2+x+1
        16'hb300, // x8+x7+x5+x4+x+1
        16'h0100, // x8+1
        16'h1021, // x16+x12+x5+1
        16'h0811  // x16+x11+x4+1
    };
    // Active stages; also the preset image
    localparam scg_word_t STAGE_MASK [NUM_POLY] = '{
        16'hffff, 16'hffff, 16'hffff, 16'hfff0,
        16'hff00, 16'hff00, 16'hffff, 16'hffff
    };
    // Right shift that brings a short remainder down to bit 0
    localparam logic [3:0] JUST_SHIFT [NUM_POLY] = '{
        4'h0, 4'h0, 4'h0, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0
    };

    // ****************************************************************
    // Register port map
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h8;
    localparam int ST_ERR_BIT = 16;
    localparam int ST_PHASE_LSB = 17;
    localparam int ST_SEL_LSB = 19;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_PRESET_BIT = 1;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Gray along idle -> data -> check
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_DATA = 2'h1,
        PH_CHECK = 2'h3
    } scg_phase_t;

    typedef struct packed {
        logic [SEL_W-1:0] polySel;
        logic dataIn;
        logic checkWordEnable;
        logic residueMatchEnableN;
        logic presetN;
        logic masterClear;
        logic shiftClockN;
    } scg_pins_t;

    // Inactive pin levels held by the synchroniser during reset
    localparam scg_pins_t PINS_IDLE = '{
        polySel: 3'h0,
        dataIn: 1'b0,
        checkWordEnable: 1'b0,
        residueMatchEnableN: 1'b1,
        presetN: 1'b1,
        masterClear: 1'b0,
        shiftClockN: 1'b1
    };

endpackage

// ===== hw/scg_sync.sv
`timescale 1ns/1ps
`default_nettype none

module scg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);

    logic [W-1:0] meta;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            synced <= RST_VAL;
        end else begin
            meta <= async;
            synced <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== tb/scg_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Controlling logic on the serial side
// ****************************************************************
module scg_ctl_model (
    input wire logic clk,
    input wire logic checkCharacter,
    output var scg_pkg::scg_pins_t pins,
    output logic lineBit
);
    // Pins start at their inactive levels
    initial begin
        pins = scg_pkg::PINS_IDLE;
    end

    // Line gating: data while dividing, check bits after
    assign lineBit = pins.checkWordEnable ? pins.dataIn : checkCharacter;

    // Select held for a whole message; sync needs settling time
    task automatic selectPoly(input logic [2:0] sel);
        @(posedge clk);
        pins.polySel <= sel;
        repeat (4) @(posedge clk);
    endtask

    // Preset and clear as independent levels
    task automatic initReg(input logic presetLow, input logic clearHigh);
        @(posedge clk);
        pins.presetN <= ~presetLow;
        pins.masterClear <= clearHigh;
        repeat (4) @(posedge clk);
        pins.presetN <= 1'b1;
        pins.masterClear <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // One bit: data settles, clock falls, stays low, rises again
    task automatic shiftBit(input logic d, input logic check_word_enable, input logic pmeN);
        @(posedge clk);
        pins.dataIn <= d;
        pins.checkWordEnable <= check_word_enable;
        pins.residueMatchEnableN <= pmeN;
        repeat (3) @(posedge clk);
        pins.shiftClockN <= 1'b0;
        repeat (4) @(posedge clk);
        pins.shiftClockN <= 1'b1;
        // Data no longer held after the edge: show the inverse
        pins.dataIn <= ~d;
        #1;
    endtask

    // Last data bit done: drop the enable so the check bits own the line
    task automatic endData();
        @(posedge clk);
        pins.checkWordEnable <= 1'b0;
        #1;
    endtask
endmodule

`default_nettype wire

// ===== tb/serial_crc_generator_checker_bench.sv
`timescale 1ns/1ps
`default_nettype none

module serial_crc_generator_checker_bench;
    localparam int LIMIT = 20000;
    localparam logic [15:0] MSG = 16'hc5a3;
    logic clk;
    logic rstn;
    logic [scg_pkg::ADDR_W-1:0] regAddr;
    logic [31:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [31:0] regRdata;
    logic checkCharacter;
    logic errorFlag;
    logic lineBit;
    scg_pkg::scg_pins_t pins;
    int numErrors;
    int totalChecks;
    int cycles;
    scg_pkg::scg_word_t model;
    logic expErr;
    logic [31:0] rd;

    scg_ctl_model ctl (.clk(clk), .checkCharacter(checkCharacter), .pins(pins),
        .lineBit(lineBit));

    scg_crc dut (.clk(clk), .rstn(rstn), .polySelBit0(pins.polySel[0]),
        .polySelBit1(pins.polySel[1]), .polySelBit2(pins.polySel[2]),
        .shiftClockN(pins.shiftClockN), .serialData(pins.dataIn),
        .checkWordEnable(pins.checkWordEnable),
        .residueMatchEnableN(pins.residueMatchEnableN), .presetN(pins.presetN),
        .masterClear(pins.masterClear), .checkCharacter(checkCharacter),
        .errorFlag(errorFlag), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

    // ****************************************************************
    // Clock, timeout and report
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short well past the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            numErrors++;
            wrapUp();
        end
    end

    task automatic wrapUp();
        if (numErrors == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ****************************************************************
    // Register port and reference division
    // ****************************************************************
    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Top-aligned MSB-first step; short divisors masked to their stages
    function automatic scg_pkg::scg_word_t nextRem(scg_pkg::scg_word_t r, logic d,
            logic check_word_enable, int sel);
        scg_pkg::scg_word_t n;
        n = r << 1;
        if (check_word_enable && (d ^ r[15]))
            n = n ^ scg_pkg::POLY_MASK[sel];
        return n & scg_pkg::STAGE_MASK[sel];
    endfunction

    task automatic initAndModel(input logic p, input logic c, input int sel);
        ctl.initReg(p, c);
        model = c ? 16'h0000 : (p ? scg_pkg::STAGE_MASK[sel] : model);
        expErr = (model != 16'h0000);
    endtask

    task automatic step(input logic d, input logic check_word_enable, input logic pmeN, input int sel);
        ctl.shiftBit(d, check_word_enable, pmeN);
        model = nextRem(model, d, check_word_enable, sel);
        expErr = pmeN ? (model != 16'h0000) : (model != scg_pkg::RESIDUE);
        check(32'(checkCharacter), 32'(model[15]), "serial out");
        if (check_word_enable)
            check(32'(errorFlag), 32'(expErr), "error flag");
    endtask

    // Whole status word, phase included; idle phase unless told otherwise
    task automatic checkStatus(input int sel, input logic [1:0] ph = scg_pkg::PH_IDLE);
        scg_pkg::scg_word_t rj;
        rj = model >> scg_pkg::JUST_SHIFT[sel];
        regRd(scg_pkg::OFS_STATUS, rd);
        check(rd, {10'h000, 3'(sel), ph, expErr, rj}, "status");
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic testReset();
        regRd(scg_pkg::OFS_STATUS, rd);
        check(rd, 32'h00000000, "status after reset");
        regRd(4'hc, rd);
        check(rd, 32'h00000000, "unmapped read");
        regRd(scg_pkg::OFS_CONTROL, rd);
        check(rd, 32'h00000000, "control read");
        check(32'({checkCharacter, errorFlag}), 32'h0, "outputs after reset");
    endtask

    task automatic testPresetClear();
        int sels[4] = '{0, 3, 4, 5};
        foreach (sels[i]) begin
            ctl.selectPoly(3'(sels[i]));
            initAndModel(1'b1, 1'b0, sels[i]);
            checkStatus(sels[i]);
            check(32'(checkCharacter), 32'h1, "preset top bit");
            initAndModel(1'b0, 1'b1, sels[i]);
            checkStatus(sels[i]);
            initAndModel(1'b1, 1'b1, sels[i]);
            checkStatus(sels[i]);
        end
    endtask

    // Every select: divide, read back, then ship the check word
    task automatic testAllPolys();
        int deg;
        for (int s = 0; s < scg_pkg::NUM_POLY; s++) begin
            deg = $countones(scg_pkg::STAGE_MASK[s]);
            ctl.selectPoly(3'(s));
            initAndModel(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--)
                step(MSG[i] ^ s[0], 1'b1, 1'b1, s);
            checkStatus(s, scg_pkg::PH_DATA);
            ctl.endData();
            for (int k = 0; k < deg; k++) begin
                check(32'(lineBit), 32'(model[15]), "check bit on line");
                step(1'b0, 1'b0, 1'b1, s);
            end
            regRd(scg_pkg::OFS_COUNT, rd);
            check(rd, 32'(16 + deg), "bit count");
        end
    endtask

    // Receive with preset; complement and match mode for the residue case
    task automatic testReceive(input int sel, input logic corrupt, input logic compl,
            input logic pmeLast);
        scg_pkg::scg_word_t rem;
        int deg;
        deg = $countones(scg_pkg::STAGE_MASK[sel]);
        ctl.selectPoly(3'(sel));
        initAndModel(1'b1, 1'b0, sel);
        for (int i = 15; i >= 0; i--)
            step(MSG[i], 1'b1, 1'b1, sel);
        rem = compl ? ~model : model;
        rem[15 - deg + 1] = rem[15 - deg + 1] ^ corrupt;
        for (int k = 0; k < deg; k++)
            step(rem[15 - k], 1'b1, (k == deg - 1) ? ~pmeLast : 1'b1, sel);
        check(32'(errorFlag), 32'(corrupt | (compl & ~pmeLast)), "verdict");
        repeat (6) @(posedge clk);
        check(32'(errorFlag), 32'(expErr), "verdict held");
    endtask

    task automatic testSoftControl();
        ctl.selectPoly(3'h3);
        regWr(scg_pkg::OFS_CONTROL, 32'h00000002);
        model = scg_pkg::STAGE_MASK[3];
        expErr = 1'b1;
        checkStatus(3);
        regWr(4'hc, 32'h00000001);
        regWr(scg_pkg::OFS_STATUS, 32'h00000001);
        checkStatus(3);
        regWr(scg_pkg::OFS_CONTROL, 32'h00000003);
        model = 16'h0000;
        expErr = 1'b0;
        checkStatus(3);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        regAddr = '0;
        regWdata = 32'h00000000;
        regWrite = 1'b0;
        regRead = 1'b0;
        numErrors = 0;
        totalChecks = 0;
        cycles = 0;
        model = 16'h0000;
        expErr = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        testReset();
        testPresetClear();
        testAllPolys();
        testReceive(0, 1'b0, 1'b0, 1'b0);
        testReceive(6, 1'b1, 1'b0, 1'b0);
        testReceive(6, 1'b0, 1'b1, 1'b1);
        testReceive(6, 1'b0, 1'b1, 1'b0);
        testSoftControl();
        wrapUp();
    end
endmodule

`default_nettype wire
